/* File: rtl/pel_regs.svh */
/*
  Register offsets, field positions, reset values and event codes of the event linker.
  Assumes byte addresses on an 8-bit register port, one 32-bit word per register.
*/
`ifndef PEL_REGS_SVH
`define PEL_REGS_SVH

`define PEL_ADC_SEL 8'h00
`define PEL_CLK_SEL 8'h04
`define PEL_TMR_SEL0 8'h08
`define PEL_TMR_OP0 8'h18
`define PEL_SLOT_LINK0 8'h28
`define PEL_SLOT_SEL0 8'h38
`define PEL_GRP_MASK0 8'h48
`define PEL_GRP_CTRL0 8'h50
`define PEL_GRP_SEL0 8'h58
`define PEL_BUF 8'h60
`define PEL_DATA 8'h64
`define PEL_DIR 8'h68
`define PEL_ENABLE 8'h6c
`define PEL_PINS 8'h70

`define PEL_EVT_COMPARE_TIMER_1 6'h1f
`define PEL_EVT_SLOT0 6'h30
`define PEL_EVT_GRP0 6'h34

`define PEL_SLOT_PIN_LSB 0
`define PEL_SLOT_MODE_LSB 4
`define PEL_SLOT_TGT_BIT 6
`define PEL_SLOT_BUF_BIT 7
`define PEL_GRP_MODE_LSB 0
`define PEL_GRP_TGT_BIT 2
`define PEL_GRP_BUF_BIT 3

`define PEL_RST_SEL 6'h00
`define PEL_RST_BYTE 8'h00
`define PEL_RST_WORD 16'h0000

`endif

/* File: rtl/pel_pkg.sv */
/*
  Types shared by the event linker: timer operations, pin conditions and pin actions.
  Assumes the offsets and codes of pel_regs.svh.
*/
package pel_pkg;
  typedef enum logic [1:0] {
    PEL_OP_START,
    PEL_OP_RESTART,
    PEL_OP_STOP,
    PEL_OP_EVCOUNT
  } pel_tmr_op_t;

  typedef enum logic [1:0] {
    PEL_COND_RISE,
    PEL_COND_FALL,
    PEL_COND_BOTH,
    PEL_COND_LEVEL
  } pel_cond_t;

  typedef enum logic [1:0] {
    PEL_ACT_HIGH,
    PEL_ACT_LOW,
    PEL_ACT_TOGGLE,
    PEL_ACT_KEEP
  } pel_act_t;
endpackage

/* File: rtl/pel_linker.sv */
/*
  Peripheral event linker: routes peripheral event pulses to converter, clock switch,
  four timers and port pins B (0..7) and E (8..15), with a plain register port.
  Assumes events arrive as one-cycle pulses on i_clock; port pins are asynchronous.
*/
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "pel_regs.svh"

module pel_linker #(
  parameter int NUM_EVT = 64,
  parameter int NUM_TMR = 4,
  parameter int NUM_SLOT = 4,
  parameter int NUM_GRP = 2
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Peripheral events and status
  input wire logic [NUM_EVT-1:0] i_evt,
  input wire logic i_compare_timer_1_wide_mode,
  // Targets
  output logic o_adc_start,
  output logic o_clk_to_low_speed_osc,
  output logic [NUM_TMR-1:0] o_tmr_start,
  output logic [NUM_TMR-1:0] o_tmr_restart,
  output logic [NUM_TMR-1:0] o_tmr_stop,
  output logic [NUM_TMR-1:0] o_tmr_evcount,
  output logic [NUM_EVT-1:0] o_irq_req,
  // Ports B and E
  input wire logic [15:0] i_port_pin,
  output logic [15:0] o_port_data,
  output logic [15:0] o_port_oe
);

  logic [5:0] adc_event_select;
  logic [5:0] clock_switch_event_select;
  logic [5:0] tmr_event_select [NUM_TMR];
  logic [1:0] timer_op_select [NUM_TMR];
  logic [7:0] port_event_link_select [NUM_SLOT];
  logic [5:0] slot_event_select [NUM_SLOT];
  logic [15:0] port_group_select [NUM_GRP];
  logic [3:0] port_group_control [NUM_GRP];
  logic [5:0] grp_event_select [NUM_GRP];
  logic [15:0] port_buffer;
  logic link_en;
  logic [15:0] pin_meta;
  logic [15:0] pin_sync;
  logic [15:0] pin_prev;
  logic [NUM_SLOT-1:0] slot_evt;
  logic [NUM_GRP-1:0] grp_evt;
  logic [NUM_EVT-1:0] evt_all;
  logic [NUM_SLOT-1:0] slot_trig;
  logic [NUM_GRP-1:0] grp_trig;
  logic [NUM_TMR-1:0] tmr_go;
  logic [31:0] next_rdata;

  // Port events take their own fixed codes; a peripheral on those codes is overridden
  always_comb begin
    evt_all = i_evt;
    for (int s = 0; s < NUM_SLOT; s++) begin
      evt_all[`PEL_EVT_SLOT0 + 6'(s)] = slot_evt[s];
    end
    for (int g = 0; g < NUM_GRP; g++) begin
      evt_all[`PEL_EVT_GRP0 + 6'(g)] = grp_evt[g];
    end
  end

  // Code zero never selects, so a cleared select register unlinks its target
  function automatic logic hit(input logic [5:0] code, input logic [NUM_EVT-1:0] evts);
    hit = (code != 6'h00) && evts[code];
  endfunction

  function automatic logic cond_met(input logic cur, input logic prev, input logic [1:0] c);
    unique case (pel_pkg::pel_cond_t'(c))
      pel_pkg::PEL_COND_RISE: cond_met = cur && !prev;
      pel_pkg::PEL_COND_FALL: cond_met = !cur && prev;
      pel_pkg::PEL_COND_BOTH: cond_met = cur != prev;
      pel_pkg::PEL_COND_LEVEL: cond_met = cur;
    endcase
  endfunction

  function automatic logic act_on(input logic cur, input logic [1:0] a);
    unique case (pel_pkg::pel_act_t'(a))
      pel_pkg::PEL_ACT_HIGH: act_on = 1'b1;
      pel_pkg::PEL_ACT_LOW: act_on = 1'b0;
      pel_pkg::PEL_ACT_TOGGLE: act_on = !cur;
      pel_pkg::PEL_ACT_KEEP: act_on = cur;
    endcase
  endfunction

  // Software configuration registers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      adc_event_select <= `PEL_RST_SEL;
      clock_switch_event_select <= `PEL_RST_SEL;
      link_en <= 1'b0;
      for (int t = 0; t < NUM_TMR; t++) begin
        tmr_event_select[t] <= `PEL_RST_SEL;
        timer_op_select[t] <= 2'h0;
      end
      for (int s = 0; s < NUM_SLOT; s++) begin
        port_event_link_select[s] <= `PEL_RST_BYTE;
        slot_event_select[s] <= `PEL_RST_SEL;
      end
      for (int g = 0; g < NUM_GRP; g++) begin
        port_group_select[g] <= `PEL_RST_WORD;
        port_group_control[g] <= 4'h0;
        grp_event_select[g] <= `PEL_RST_SEL;
      end
      o_port_oe <= `PEL_RST_WORD;
    end else if (i_wr) begin
      if (i_addr == `PEL_ADC_SEL) adc_event_select <= i_wdata[5:0];
      if (i_addr == `PEL_CLK_SEL) clock_switch_event_select <= i_wdata[5:0];
      if (i_addr == `PEL_ENABLE) link_en <= i_wdata[0];
      if (i_addr == `PEL_DIR) o_port_oe <= i_wdata[15:0];
      for (int t = 0; t < NUM_TMR; t++) begin
        if (i_addr == `PEL_TMR_SEL0 + 8'(4 * t)) tmr_event_select[t] <= i_wdata[5:0];
        if (i_addr == `PEL_TMR_OP0 + 8'(4 * t)) timer_op_select[t] <= i_wdata[1:0];
      end
      for (int s = 0; s < NUM_SLOT; s++) begin
        if (i_addr == `PEL_SLOT_LINK0 + 8'(4 * s)) port_event_link_select[s] <= i_wdata[7:0];
        if (i_addr == `PEL_SLOT_SEL0 + 8'(4 * s)) slot_event_select[s] <= i_wdata[5:0];
      end
      for (int g = 0; g < NUM_GRP; g++) begin
        if (i_addr == `PEL_GRP_MASK0 + 8'(4 * g)) port_group_select[g] <= i_wdata[15:0];
        if (i_addr == `PEL_GRP_CTRL0 + 8'(4 * g)) port_group_control[g] <= i_wdata[3:0];
        if (i_addr == `PEL_GRP_SEL0 + 8'(4 * g)) grp_event_select[g] <= i_wdata[5:0];
      end
    end
  end

  // Pins are asynchronous; only the second and third stages are looked at
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_meta <= `PEL_RST_WORD;
      pin_sync <= `PEL_RST_WORD;
      pin_prev <= `PEL_RST_WORD;
    end else begin
      pin_meta <= i_port_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Port source events
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slot_evt <= '0;
      grp_evt <= '0;
    end else begin
      for (int s = 0; s < NUM_SLOT; s++) begin
        slot_evt[s] <= link_en && !port_event_link_select[s][`PEL_SLOT_TGT_BIT] &&
          cond_met(pin_sync[port_event_link_select[s][3:0]],
                   pin_prev[port_event_link_select[s][3:0]],
                   port_event_link_select[s][5:4]);
      end
      for (int g = 0; g < NUM_GRP; g++) begin
        grp_evt[g] <= 1'b0;
        for (int p = 0; p < 16; p++) begin
          if (link_en && !port_group_control[g][`PEL_GRP_TGT_BIT] &&
              port_group_select[g][p] &&
              cond_met(pin_sync[p], pin_prev[p], port_group_control[g][1:0])) begin
            grp_evt[g] <= 1'b1;
          end
        end
      end
    end
  end

  // Port target triggers
  always_comb begin
    for (int s = 0; s < NUM_SLOT; s++) begin
      slot_trig[s] = link_en && port_event_link_select[s][`PEL_SLOT_TGT_BIT] &&
        hit(slot_event_select[s], evt_all);
    end
    for (int g = 0; g < NUM_GRP; g++) begin
      grp_trig[g] = link_en && port_group_control[g][`PEL_GRP_TGT_BIT] &&
        hit(grp_event_select[g], evt_all);
    end
  end

  // Output data and buffer; a trigger beats a software write in the same cycle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_port_data <= `PEL_RST_WORD;
      port_buffer <= `PEL_RST_WORD;
    end else begin
      if (i_wr && i_addr == `PEL_DATA) o_port_data <= i_wdata[15:0];
      if (i_wr && i_addr == `PEL_BUF) port_buffer <= i_wdata[15:0];
      for (int p = 0; p < 16; p++) begin
        for (int s = 0; s < NUM_SLOT; s++) begin
          if (slot_trig[s] && port_event_link_select[s][3:0] == 4'(p)) begin
            if (!port_event_link_select[s][`PEL_SLOT_BUF_BIT]) begin
              o_port_data[p] <= act_on(o_port_data[p], port_event_link_select[s][5:4]);
            end else if (o_port_oe[p]) begin
              o_port_data[p] <= port_buffer[p];
            end else begin
              port_buffer[p] <= pin_sync[p];
            end
          end
        end
        for (int g = 0; g < NUM_GRP; g++) begin
          if (grp_trig[g] && port_group_select[g][p]) begin
            if (!port_group_control[g][`PEL_GRP_BUF_BIT]) begin
              o_port_data[p] <= act_on(o_port_data[p], port_group_control[g][1:0]);
            end else if (o_port_oe[p]) begin
              o_port_data[p] <= port_buffer[p];
            end else begin
              port_buffer[p] <= pin_sync[p];
            end
          end
        end
      end
    end
  end

  // Timer 0 is compare timer 1; its wide mode refuses links
  always_comb begin
    for (int t = 0; t < NUM_TMR; t++) begin
      tmr_go[t] = link_en && hit(tmr_event_select[t], evt_all) &&
        !(t == 0 && i_compare_timer_1_wide_mode);
    end
  end

  // Target actions; every target decodes independently so one event can fan out
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_adc_start <= 1'b0;
      o_clk_to_low_speed_osc <= 1'b0;
      o_tmr_start <= '0;
      o_tmr_restart <= '0;
      o_tmr_stop <= '0;
      o_tmr_evcount <= '0;
    end else begin
      o_adc_start <= link_en && hit(adc_event_select, evt_all);
      o_clk_to_low_speed_osc <= link_en && hit(clock_switch_event_select, evt_all);
      for (int t = 0; t < NUM_TMR; t++) begin
        o_tmr_start[t] <= tmr_go[t] && timer_op_select[t] == pel_pkg::PEL_OP_START;
        o_tmr_restart[t] <= tmr_go[t] && timer_op_select[t] == pel_pkg::PEL_OP_RESTART;
        o_tmr_stop[t] <= tmr_go[t] && timer_op_select[t] == pel_pkg::PEL_OP_STOP;
        o_tmr_evcount[t] <= tmr_go[t] && timer_op_select[t] == pel_pkg::PEL_OP_EVCOUNT;
      end
    end
  end

  // Interrupt path ignores the enable, it runs beside the link
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_req <= '0;
    end else begin
      o_irq_req <= evt_all;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (i_addr == `PEL_ADC_SEL) next_rdata[5:0] = adc_event_select;
    if (i_addr == `PEL_CLK_SEL) next_rdata[5:0] = clock_switch_event_select;
    if (i_addr == `PEL_BUF) next_rdata[15:0] = port_buffer;
    if (i_addr == `PEL_DATA) next_rdata[15:0] = o_port_data;
    if (i_addr == `PEL_DIR) next_rdata[15:0] = o_port_oe;
    if (i_addr == `PEL_ENABLE) next_rdata[0] = link_en;
    if (i_addr == `PEL_PINS) next_rdata[15:0] = pin_sync;
    for (int t = 0; t < NUM_TMR; t++) begin
      if (i_addr == `PEL_TMR_SEL0 + 8'(4 * t)) next_rdata[5:0] = tmr_event_select[t];
      if (i_addr == `PEL_TMR_OP0 + 8'(4 * t)) next_rdata[1:0] = timer_op_select[t];
    end
    for (int s = 0; s < NUM_SLOT; s++) begin
      if (i_addr == `PEL_SLOT_LINK0 + 8'(4 * s)) next_rdata[7:0] = port_event_link_select[s];
      if (i_addr == `PEL_SLOT_SEL0 + 8'(4 * s)) next_rdata[5:0] = slot_event_select[s];
    end
    for (int g = 0; g < NUM_GRP; g++) begin
      if (i_addr == `PEL_GRP_MASK0 + 8'(4 * g)) next_rdata[15:0] = port_group_select[g];
      if (i_addr == `PEL_GRP_CTRL0 + 8'(4 * g)) next_rdata[3:0] = port_group_control[g];
      if (i_addr == `PEL_GRP_SEL0 + 8'(4 * g)) next_rdata[5:0] = grp_event_select[g];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= i_rd ? next_rdata : 32'h0000_0000;
    end
  end

  compare_timer_1_to_adc_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    link_en && adc_event_select == `PEL_EVT_COMPARE_TIMER_1 && i_evt[31] |=> o_adc_start)
    else $error("compare timer event did not start conversion");
  adc_zero_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    adc_event_select == 6'h00 |=> !o_adc_start)
    else $error("conversion started with select zero");
  clk_switch_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_clk_to_low_speed_osc |-> $past(link_en) && $past(clock_switch_event_select) != 6'h00)
    else $error("clock switch without routed event");
  tmr_op_one_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $onehot0({o_tmr_start[1], o_tmr_restart[1], o_tmr_stop[1], o_tmr_evcount[1]}))
    else $error("timer got two operations at once");
  compare_timer_1_wide_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_compare_timer_1_wide_mode |=> !o_tmr_start[0] && !o_tmr_stop[0] && !o_tmr_restart[0] &&
    !o_tmr_evcount[0])
    else $error("wide compare timer took a linked action");
  irq_parallel_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !link_en && i_evt[31] |=> o_irq_req[31])
    else $error("event not passed to interrupt unit");
  fan_out_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    link_en && adc_event_select == clock_switch_event_select && hit(adc_event_select, evt_all)
    |=> o_adc_start && o_clk_to_low_speed_osc)
    else $error("event did not reach both targets");
  link_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !link_en [*2] |-> !o_adc_start && slot_evt == '0)
    else $error("action while linker disabled");
  slot_edge_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    link_en && port_event_link_select[1] == 8'h0d && $rose(pin_sync[13]) |=> slot_evt[1] ##1
    (!slot_evt[1] || $rose(pin_sync[13])))
    else $error("pin edge event not a single pulse");

endmodule

/* File: test/pel_periph_model.sv */
/*
  Far-side peripherals: event pulse source and the pads of ports B and E.
  Assumes requests change just after a rising edge of the shared clock.
*/
`timescale 1ns/1ps
module pel_periph_model (
  // Clock
  input wire logic i_clock,
  // Event requests
  input wire logic i_fire,
  input wire logic [5:0] i_code,
  output logic [63:0] o_evt,
  // Pads
  input wire logic [15:0] i_ext,
  input wire logic [15:0] i_data,
  input wire logic [15:0] i_oe,
  output logic [15:0] o_pin
);
  initial o_evt = 64'h0;
  // One request gives exactly one cycle of pulse
  always @(posedge i_clock) begin
    o_evt <= i_fire ? (64'h1 << i_code) : 64'h0;
  end
  // Driven pads show port data, the rest the outside level
  assign o_pin = (i_oe & i_data) | (~i_oe & i_ext);
endmodule

/* File: test/pel_tb.sv */
/*
  Self-checking bench of the event linker: register tasks, event firing, pin stimulus.
  Assumes the linker and the peripheral model share one 250 MHz clock.
*/
`timescale 1ns/1ps
`include "pel_regs.svh"
module testbench;
  logic clock;
  logic rst_n;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic fire;
  logic [5:0] code;
  logic [63:0] evt;
  logic wide;
  logic [15:0] ext;
  logic [15:0] pin;
  logic adc;
  logic clk_sw;
  logic [3:0] t_start;
  logic [3:0] t_restart;
  logic [3:0] t_stop;
  logic [3:0] t_count;
  logic [63:0] irq;
  logic [15:0] pdata;
  logic [15:0] poe;
  logic [31:0] seen;
  int n;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] acts [5] = '{8'h43, 8'h63, 8'h63, 8'h53, 8'h73};
  logic [15:0] lvl [5] = '{16'h0008, 16'h0000, 16'h0008, 16'h0000, 16'h0000};

  pel_linker dut (.i_clock(clock), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_evt(evt), .i_compare_timer_1_wide_mode(wide),
    .o_adc_start(adc), .o_clk_to_low_speed_osc(clk_sw), .o_tmr_start(t_start),
    .o_tmr_restart(t_restart), .o_tmr_stop(t_stop), .o_tmr_evcount(t_count),
    .o_irq_req(irq), .i_port_pin(pin), .o_port_data(pdata), .o_port_oe(poe));
  pel_periph_model periph (.i_clock(clock), .i_fire(fire), .i_code(code), .o_evt(evt),
    .i_ext(ext), .i_data(pdata), .i_oe(poe), .o_pin(pin));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // Linked settings change only while the linker is off
  task automatic cfg_reg(input logic [7:0] a, input logic [31:0] d);
    wr_reg(`PEL_ENABLE, 32'h0);
    wr_reg(a, d);
    wr_reg(`PEL_ENABLE, 32'h1);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    seen = rdata;
  endtask

  // Returns just after the edge that launches the target pulse
  task automatic fire_evt(input logic [5:0] c);
    @(posedge clock);
    fire <= 1'b1;
    code <= c;
    @(posedge clock);
    fire <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  // Counts target pulses over ten cycles; 0 watches the converter, 1 the clock switch
  task automatic count_pulses(input int which, output int hits);
    hits = 0;
    repeat (10) begin
      @(posedge clock);
      #1;
      if ((which == 0 ? adc : clk_sw) === 1'b1) hits++;
    end
  endtask

  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    fire = 1'b0;
    code = 6'h00;
    wide = 1'b0;
    ext = 16'h0000;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd_reg(`PEL_ADC_SEL);
    chk("adc_sel_reset", 32'h0, seen);
    rd_reg(`PEL_ENABLE);
    chk("enable_reset", 32'h0, seen);
    wr_reg(8'h7c, 32'hffff_ffff);
    rd_reg(8'h7c);
    chk("unmapped", 32'h0, seen);
    $display("test reset done");
    wr_reg(`PEL_ADC_SEL, 32'h1f);
    wr_reg(`PEL_ENABLE, 32'h1);
    rd_reg(`PEL_ADC_SEL);
    chk("adc_sel", 32'h1f, seen);
    fire_evt(`PEL_EVT_COMPARE_TIMER_1);
    chk("adc_start", 32'h1, {31'h0, adc});
    chk("irq_low", 32'h8000_0000, irq[31:0]);
    @(posedge clock);
    #1;
    chk("adc_start_end", 32'h0, {31'h0, adc});
    wr_reg(`PEL_ENABLE, 32'h0);
    fire_evt(`PEL_EVT_COMPARE_TIMER_1);
    chk("adc_disabled", 32'h0, {31'h0, adc});
    chk("irq_disabled", 32'h8000_0000, irq[31:0]);
    wr_reg(`PEL_ADC_SEL, 32'h0);
    wr_reg(`PEL_ENABLE, 32'h1);
    fire_evt(6'h00);
    chk("adc_code_zero", 32'h0, {31'h0, adc});
    $display("test converter done");
    for (int t = 0; t < 4; t++) begin
      cfg_reg(`PEL_TMR_SEL0 + 8'(4 * t), 32'd10);
      cfg_reg(`PEL_TMR_OP0 + 8'(4 * t), 32'(t));
    end
    cfg_reg(`PEL_CLK_SEL, 32'd10);
    fire_evt(6'd10);
    chk("timer_ops", 32'h8421, {16'h0, t_count, t_stop, t_restart, t_start});
    chk("clk_switch", 32'h1, {31'h0, clk_sw});
    // Wide mode is a timer setting, so it also changes with the linker off
    wr_reg(`PEL_ENABLE, 32'h0);
    wide <= 1'b1;
    wr_reg(`PEL_ENABLE, 32'h1);
    fire_evt(6'd10);
    chk("timer_wide", 32'h8420, {16'h0, t_count, t_stop, t_restart, t_start});
    wr_reg(`PEL_ENABLE, 32'h0);
    wide <= 1'b0;
    wr_reg(`PEL_ENABLE, 32'h1);
    $display("test timers done");
    cfg_reg(`PEL_DIR, 32'h0f08);
    cfg_reg(`PEL_SLOT_SEL0, 32'd12);
    for (int i = 0; i < 5; i++) begin
      cfg_reg(`PEL_SLOT_LINK0, 32'(acts[i]));
      fire_evt(6'd12);
      chk("slot_action", 32'(lvl[i]), 32'(pdata & 16'h0008));
    end
    chk("port_dir", 32'h0f08, 32'(poe));
    $display("test pin actions done");
    cfg_reg(`PEL_GRP_MASK0, 32'h0f00);
    wr_reg(`PEL_BUF, 32'h0500);
    cfg_reg(`PEL_GRP_CTRL0, 32'h0c);
    cfg_reg(`PEL_GRP_SEL0, 32'd14);
    fire_evt(6'd14);
    chk("group_buf_out", 32'h0500, 32'(pdata & 16'h0f00));
    cfg_reg(`PEL_SLOT_LINK0 + 8'h08, 32'hc4);
    ext <= 16'h0010;
    cfg_reg(`PEL_SLOT_SEL0 + 8'h08, 32'd13);
    fire_evt(6'd13);
    rd_reg(`PEL_BUF);
    chk("slot_buf_in", 32'h0510, seen);
    $display("test buffers done");
    cfg_reg(`PEL_SLOT_LINK0 + 8'h04, 32'h0d);
    cfg_reg(`PEL_ADC_SEL, 32'h31);
    ext <= 16'h2010;
    count_pulses(0, n);
    chk("pin_rise", 32'd1, 32'(n));
    cfg_reg(`PEL_SLOT_LINK0 + 8'h04, 32'h3d);
    // Skip the synchroniser and event pipeline before counting
    repeat (3) @(posedge clock);
    count_pulses(0, n);
    chk("pin_level", 32'd10, 32'(n));
    cfg_reg(`PEL_ADC_SEL, 32'h0);
    cfg_reg(`PEL_GRP_MASK0 + 8'h04, 32'h0004);
    cfg_reg(`PEL_CLK_SEL, 32'h35);
    ext <= 16'h2014;
    count_pulses(1, n);
    chk("group_rise", 32'd1, 32'(n));
    $display("test pin sources done");
    end_of_test();
  end
endmodule
